// File: slc_pkg.sv
// Package of offsets, bit positions, reset values and carrier types for the serial link control bank.
//
// Summary of operation
// - Base status shows one bit per channel, set while that channel requests interrupt.
// - Two base status bits report clock buffer lock, one when locked.
// - Each PLL FIFO reports empty, full and data-valid; valid covers the output stage.
// - PLL ready reads one only while the programmer is idle.
// - Programmer success latches done until host writes one to that bit.
// - Programmer failure latches error until host writes one to that bit.
// - Base status carries a read-only bus core revision field.
// - FIFO port writes push PLL transmit FIFO, reads pop receive FIFO; 32x32.
// - Control bits are active high, reset to zero; active-low outputs are inverted copies.
// - FIFO reset bits reset data FIFOs; host holds them two clocks at least.
// - Loop-back moves transmit FIFO words straight into the receive FIFO.
// - Transmitter enable gates the transmit machine with data, trigger and send bits.
// - DMA priority bits favour urgent channels, otherwise arbitration is round-robin.
// - Master enable gates all non-DMA channel interrupts to the host.
// - Force interrupt raises an interrupt when master enable is set.
// - Almost-empty interrupt when transmit level at or below its threshold.
// - Almost-full interrupt when receive level at or above its threshold.
// - Overflow interrupt on writing a full receive FIFO; latched status kept.
// - Receiver packs data bytes LSB first; partial word zero-filled on disable.
// - DMA completion interrupt enables act without the master enable.
// - Trigger mode waits for trigger, else send bit; trigger enable clears after frame.
// - Transmit test pattern runs while transmitter enable, test enable and load pattern are all set.
package slc_pkg;

   localparam int          ADDR_W          = 12;
   localparam int          CNT_W           = 16;
   localparam int          NUM_CH          = 2;
   localparam int          PLL_FIFO_DEPTH  = 32;

   localparam logic [11:0] OFS_BASE_STATUS = 12'h008;
   localparam logic [11:0] OFS_PLL_FIFO    = 12'h00C;
   localparam logic [11:0] OFS_CHAN0_CTRL  = 12'h020;
   localparam logic [11:0] OFS_CHAN1_CTRL  = 12'h050;

   localparam int          ST_CH_IRQ       = 0;
   localparam int          ST_PLL_LOCK     = 6;
   localparam int          ST_LINK_LOCK    = 7;
   localparam int          ST_WF_EMPTY     = 8;
   localparam int          ST_RF_EMPTY     = 12;
   localparam int          ST_PLL_READY    = 16;
   localparam int          ST_PLL_DONE     = 17;
   localparam int          ST_PLL_ERR      = 18;
   localparam int          ST_CORE_REV     = 20;

   localparam logic [31:0] CHAN_CTRL_RST   = 32'h0000_0000;
   localparam logic [31:0] CHAN_CTRL_MASK  = 32'h0F3F_FFFF;

   typedef struct packed {
      logic [3:0] spare_hi;
      logic       reframe_init;
      logic [1:0] dma_count_sel;
      logic       send_now;
      logic [1:0] spare_mid;
      logic       force_reframe;
      logic       test_mode;
      logic       rx_test_en;
      logic       rx_ext_sel;
      logic       tx_load_pattern;
      logic       tx_ext_oe;
      logic       tx_test_en;
      logic       trig_en;
      logic       rd_dma_ie;
      logic       wr_dma_ie;
      logic       rx_en;
      logic       ovf_ie;
      logic       afull_ie;
      logic       aempty_ie;
      logic       force_irq;
      logic       master_ie;
      logic       rd_prio;
      logic       wr_prio;
      logic       tx_en;
      logic       loopback;
      logic       rx_fifo_rst;
      logic       tx_fifo_rst;
   } slc_chan_ctrl_t;

   typedef struct packed {
      logic [CNT_W-1:0] tx_count;
      logic [CNT_W-1:0] rx_count;
      logic [CNT_W-1:0] tx_almost_empty_threshold;
      logic [CNT_W-1:0] rx_almost_full_threshold;
      logic [31:0]      tx_word;
      logic             tx_word_valid;
      logic             tx_has_data;
      logic             rx_full;
      logic             rx_wr_try;
      logic             ovf_clr;
      logic [7:0]       rx_byte;
      logic             rx_byte_valid;
      logic             rx_byte_is_data;
      logic             trig_req;
      logic             frame_done;
      logic             wr_dma_req;
      logic             rd_dma_req;
      logic             wr_dma_done;
      logic             rd_dma_done;
   } slc_chan_in_t;

   typedef struct packed {
      slc_chan_ctrl_t ctrl;
      logic           tx_fifo_rst_n;
      logic           rx_fifo_rst_n;
      logic           tx_go;
      logic           tx_pattern_send;
      logic           tx_pop;
      logic           ovf_latched;
      logic           irq;
      logic [31:0]    rx_word;
      logic           rx_word_valid;
   } slc_chan_out_t;

endpackage

// File: slc_pll_model.sv
// Behavioural PLL programmer standing on the far side of the PLL FIFOs.
`timescale 1ns/100ps
`default_nettype none
module slc_pll_model
(
   input  wire logic        clk,
   input  wire logic [1:0]  mode,
   input  wire logic [31:0] tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic [31:0]      rx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready
);
   logic [31:0] got [$];
   logic [31:0] feed [$];
   initial
   begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data = 32'h0000_0000;
   end
   // Mode 0 stalls, 1 takes a word every cycle, 2 every other cycle; idle read data is scrambled.
   always @(posedge clk)
   begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      if (rx_valid && rx_ready)
         void'(feed.pop_front());
      tx_ready <= (mode == 2'h1) || (mode == 2'h2 && !tx_ready);
      rx_valid <= (feed.size() > 0);
      rx_data <= (feed.size() > 0) ? feed[0] : ~rx_data;
   end
endmodule  // slc_pll_model
`default_nettype wire

// File: slc_top.sv
// Control and status register bank with PLL FIFOs, channel control and DMA arbitration.
`timescale 1ns/100ps
`default_nettype none
module slc_top
   import slc_pkg::*;
#(
   parameter int          DEPTH    = PLL_FIFO_DEPTH,
   parameter logic [7:0]  CORE_REV = 8'h5A  // Arbitrary value.
)
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  reg_wr,
   input  wire logic                  reg_rd,
   input  wire logic [ADDR_W-1:0]     reg_addr,
   input  wire logic [31:0]           reg_wdata,
   output logic      [31:0]           reg_rdata,
   input  wire logic                  pll_lock_raw,
   input  wire logic                  link_lock_raw,
   input  wire logic                  pll_busy,
   input  wire logic                  pll_done_evt,
   input  wire logic                  pll_err_evt,
   output logic      [31:0]           pll_tx_data,
   output logic                       pll_tx_valid,
   input  wire logic                  pll_tx_ready,
   input  wire logic [31:0]           pll_rx_data,
   input  wire logic                  pll_rx_valid,
   output logic                       pll_rx_ready,
   input  wire slc_chan_in_t          chan_in  [NUM_CH],
   output slc_chan_out_t              chan_out [NUM_CH],
   output logic      [NUM_CH-1:0]     dma_grant
);

   localparam int PTR_W = $clog2(DEPTH);

   logic [1:0]         lock_s1_reg;
   logic [1:0]         lock_s2_reg;
   logic               done_reg;
   logic               err_reg;
   logic [31:0]        rdata_reg;
   slc_chan_ctrl_t     ctrl_reg  [NUM_CH];
   logic [NUM_CH-1:0]  irq_reg;
   logic [NUM_CH-1:0]  grant_reg;
   logic               rr_reg;
   logic [NUM_CH-1:0]  urgent;
   logic [NUM_CH-1:0]  req;
   logic [NUM_CH-1:0]  grant_next;
   logic               st_wr;
   logic               fifo_wr;
   logic               fifo_rd;

   // PLL FIFO 0 carries host writes to the programmer, FIFO 1 carries programmer reads to the host.
   logic [1:0]         f_push;
   logic [1:0]         f_pop;
   logic [31:0]        f_din   [2];
   logic [31:0]        f_dout  [2];
   logic [1:0]         f_valid;
   logic [1:0]         f_full;
   logic [1:0]         f_empty;

   assign st_wr   = reg_wr && (reg_addr == OFS_BASE_STATUS);
   assign fifo_wr = reg_wr && (reg_addr == OFS_PLL_FIFO);
   assign fifo_rd = reg_rd && (reg_addr == OFS_PLL_FIFO);

   // Lock flags come from another clock domain.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         lock_s1_reg <= 2'h0;
         lock_s2_reg <= 2'h0;
      end
      else
      begin
         lock_s1_reg <= {link_lock_raw, pll_lock_raw};
         lock_s2_reg <= lock_s1_reg;
      end
   end

   // Latched programmer flags; a new event beats a clearing write in the same cycle.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         done_reg <= 1'b0;
         err_reg  <= 1'b0;
      end
      else
      begin
         if (pll_done_evt)
            done_reg <= 1'b1;
         else if (st_wr && reg_wdata[ST_PLL_DONE])
            done_reg <= 1'b0;
         if (pll_err_evt)
            err_reg <= 1'b1;
         else if (st_wr && reg_wdata[ST_PLL_ERR])
            err_reg <= 1'b0;
      end
   end

   assign f_push[0]    = fifo_wr;
   assign f_din[0]     = reg_wdata;
   assign f_pop[0]     = pll_tx_ready && f_valid[0];
   assign pll_tx_data  = f_dout[0];
   assign pll_tx_valid = f_valid[0];
   assign f_push[1]    = pll_rx_valid;
   assign f_din[1]     = pll_rx_data;
   assign f_pop[1]     = fifo_rd && f_valid[1];
   assign pll_rx_ready = !f_full[1];

   for (genvar f = 0; f < 2; f++)
   begin : g_pll_fifo
      logic [31:0]    mem [DEPTH];
      logic [PTR_W-1:0] wp_reg;
      logic [PTR_W-1:0] rp_reg;
      logic [PTR_W:0]   cnt_reg;
      logic [31:0]    pipe_reg;
      logic           pipe_v_reg;
      logic           do_push;
      logic           do_load;

      assign f_full[f]  = (cnt_reg == (PTR_W+1)'(DEPTH));
      assign f_empty[f] = (cnt_reg == '0);
      assign f_valid[f] = pipe_v_reg;
      assign f_dout[f]  = pipe_reg;
      assign do_push    = f_push[f] && !f_full[f];
      assign do_load    = !f_empty[f] && (!pipe_v_reg || f_pop[f]);

      always_ff @(posedge clk)
      begin
         if (do_push)
            mem[wp_reg] <= f_din[f];
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            wp_reg     <= '0;
            rp_reg     <= '0;
            cnt_reg    <= '0;
            pipe_reg   <= 32'h0000_0000;
            pipe_v_reg <= 1'b0;
         end
         else
         begin
            if (do_push)
               wp_reg <= wp_reg + 1'b1;
            if (do_load)
            begin
               rp_reg     <= rp_reg + 1'b1;
               pipe_reg   <= mem[rp_reg];
               pipe_v_reg <= 1'b1;
            end
            else if (f_pop[f])
               pipe_v_reg <= 1'b0;
            cnt_reg <= cnt_reg + (PTR_W+1)'(do_push) - (PTR_W+1)'(do_load);
         end
      end
   end

   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_chan
      logic [11:0] my_ofs;
      logic        ctrl_wr;
      logic        ae;
      logic        af;
      logic        ovf_reg;
      logic        rx_en_d_reg;
      logic [1:0]  idx_reg;
      logic [31:0] pack_reg;
      logic [31:0] word_reg;
      logic        word_v_reg;
      logic        go_reg;
      logic        pat_reg;
      logic        byte_take;

      assign my_ofs  = (c == 0) ? OFS_CHAN0_CTRL : OFS_CHAN1_CTRL;
      assign ctrl_wr = reg_wr && (reg_addr == my_ofs);
      assign ae      = chan_in[c].tx_count <= chan_in[c].tx_almost_empty_threshold;
      assign af      = chan_in[c].rx_count >= chan_in[c].rx_almost_full_threshold;

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
            ctrl_reg[c] <= CHAN_CTRL_RST;
         else if (ctrl_wr)
            ctrl_reg[c] <= slc_chan_ctrl_t'(reg_wdata & CHAN_CTRL_MASK);
         else if (chan_in[c].frame_done)
            ctrl_reg[c].trig_en <= 1'b0;
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
            ovf_reg <= 1'b0;
         else if (chan_in[c].rx_wr_try && chan_in[c].rx_full)
            ovf_reg <= 1'b1;
         else if (chan_in[c].ovf_clr)
            ovf_reg <= 1'b0;
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
            irq_reg[c] <= 1'b0;
         else
            irq_reg[c] <= (ctrl_reg[c].master_ie &&
                           (ctrl_reg[c].force_irq ||
                            (ctrl_reg[c].aempty_ie && ae) ||
                            (ctrl_reg[c].afull_ie && af) ||
                            (ctrl_reg[c].ovf_ie && ovf_reg))) ||
                          (ctrl_reg[c].wr_dma_ie && chan_in[c].wr_dma_done) ||
                          (ctrl_reg[c].rd_dma_ie && chan_in[c].rd_dma_done);
      end

      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            go_reg  <= 1'b0;
            pat_reg <= 1'b0;
         end
         else
         begin
            go_reg  <= ctrl_reg[c].tx_en && chan_in[c].tx_has_data &&
                       (ctrl_reg[c].trig_en ? chan_in[c].trig_req : ctrl_reg[c].send_now);
            pat_reg <= ctrl_reg[c].tx_en && ctrl_reg[c].tx_test_en && ctrl_reg[c].tx_load_pattern;
         end
      end

      assign byte_take = ctrl_reg[c].rx_en && chan_in[c].rx_byte_valid && chan_in[c].rx_byte_is_data;

      // Loop-back words take the receive path; the packer stops and takes no receive bytes meanwhile.
      always_ff @(posedge clk or posedge rst)
      begin
         if (rst)
         begin
            rx_en_d_reg <= 1'b0;
            idx_reg     <= 2'h0;
            pack_reg    <= 32'h0000_0000;
            word_reg    <= 32'h0000_0000;
            word_v_reg  <= 1'b0;
         end
         else
         begin
            rx_en_d_reg <= ctrl_reg[c].rx_en;
            word_v_reg  <= 1'b0;
            if (ctrl_reg[c].loopback)
            begin
               if (chan_in[c].tx_word_valid)
               begin
                  word_reg   <= chan_in[c].tx_word;
                  word_v_reg <= 1'b1;
               end
            end
            else if (byte_take)
            begin
               if (idx_reg == 2'h3)
               begin
                  word_reg   <= {chan_in[c].rx_byte, pack_reg[23:0]};
                  word_v_reg <= 1'b1;
                  pack_reg   <= 32'h0000_0000;
               end
               else
                  pack_reg[idx_reg*8 +: 8] <= chan_in[c].rx_byte;
               idx_reg <= idx_reg + 2'h1;
            end
            else if (rx_en_d_reg && !ctrl_reg[c].rx_en && (idx_reg != 2'h0))
            begin
               word_reg   <= pack_reg;
               word_v_reg <= 1'b1;
               pack_reg   <= 32'h0000_0000;
               idx_reg    <= 2'h0;
            end
         end
      end

      assign chan_out[c].ctrl            = ctrl_reg[c];
      assign chan_out[c].tx_fifo_rst_n   = !ctrl_reg[c].tx_fifo_rst;
      assign chan_out[c].rx_fifo_rst_n   = !ctrl_reg[c].rx_fifo_rst;
      assign chan_out[c].tx_go           = go_reg;
      assign chan_out[c].tx_pattern_send = pat_reg;
      assign chan_out[c].tx_pop          = ctrl_reg[c].loopback && chan_in[c].tx_word_valid;
      assign chan_out[c].ovf_latched     = ovf_reg;
      assign chan_out[c].irq             = irq_reg[c];
      assign chan_out[c].rx_word         = word_reg;
      assign chan_out[c].rx_word_valid   = word_v_reg;

      assign req[c]    = chan_in[c].wr_dma_req || chan_in[c].rd_dma_req;
      assign urgent[c] = (ctrl_reg[c].wr_prio && chan_in[c].wr_dma_req && ae) ||
                         (ctrl_reg[c].rd_prio && chan_in[c].rd_dma_req && af);
   end

   // A grant stands while its request stays; a free bus goes to an urgent channel first.
   always_comb
   begin
      grant_next = grant_reg & req;
      if (grant_next == '0)
      begin
         if (urgent != '0)
            grant_next = (urgent[rr_reg] || !urgent[!rr_reg]) ? (NUM_CH'(1) << rr_reg)
                                                               : (NUM_CH'(1) << !rr_reg);
         else if (req[rr_reg])
            grant_next = NUM_CH'(1) << rr_reg;
         else if (req[!rr_reg])
            grant_next = NUM_CH'(1) << !rr_reg;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         grant_reg <= '0;
         rr_reg    <= 1'b0;
      end
      else
      begin
         grant_reg <= grant_next;
         if (grant_next != '0 && grant_next != grant_reg)
            rr_reg <= !grant_next[1];
      end
   end

   assign dma_grant = grant_reg;

   // Read data is registered and appears the cycle after the read strobe.
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         rdata_reg <= 32'h0000_0000;
      else if (reg_rd)
      begin
         if (reg_addr == OFS_BASE_STATUS)
         begin
            rdata_reg <= 32'h0000_0000;
            rdata_reg[ST_CH_IRQ +: NUM_CH] <= irq_reg;
            rdata_reg[ST_PLL_LOCK]         <= lock_s2_reg[0];
            rdata_reg[ST_LINK_LOCK]        <= lock_s2_reg[1];
            rdata_reg[ST_WF_EMPTY +: 3]    <= {f_valid[0], f_full[0], f_empty[0]};
            rdata_reg[ST_RF_EMPTY +: 3]    <= {f_valid[1], f_full[1], f_empty[1]};
            rdata_reg[ST_PLL_READY]        <= !pll_busy;
            rdata_reg[ST_PLL_DONE]         <= done_reg;
            rdata_reg[ST_PLL_ERR]          <= err_reg;
            rdata_reg[ST_CORE_REV +: 8]    <= CORE_REV;
         end
         else if (reg_addr == OFS_PLL_FIFO)
            rdata_reg <= f_valid[1] ? f_dout[1] : 32'h0000_0000;
         else if (reg_addr == OFS_CHAN0_CTRL)
            rdata_reg <= ctrl_reg[0];
         else if (reg_addr == OFS_CHAN1_CTRL)
            rdata_reg <= ctrl_reg[1];
         else
            rdata_reg <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   sequence s_done_evt;
      pll_done_evt;
   endsequence
   sequence s_done_clr;
      !pll_done_evt && st_wr && reg_wdata[ST_PLL_DONE];
   endsequence

   a_done_set: assert property (s_done_evt |=> done_reg)
      else $error("done flag not set after event");
   a_done_clear: assert property (s_done_clr |=> !done_reg)
      else $error("done flag not cleared by write of one");
   a_err_hold: assert property (err_reg && !(st_wr && reg_wdata[ST_PLL_ERR]) |=> err_reg)
      else $error("error flag dropped without clearing write");
   a_status_ready: assert property (reg_rd && reg_addr == OFS_BASE_STATUS
                                    |=> reg_rdata[ST_PLL_READY] == !$past(pll_busy))
      else $error("ready bit does not follow programmer state");
   a_fifo_full_push: assert property (f_full[0] && fifo_wr && !f_pop[0] |=> f_full[0])
      else $error("write FIFO full state lost on refused push");
   a_force_irq: assert property (ctrl_reg[1].master_ie && ctrl_reg[1].force_irq |=> irq_reg[1])
      else $error("forced interrupt did not reach channel 1");
   a_master_gate: assert property (!ctrl_reg[1].master_ie && !ctrl_reg[1].wr_dma_ie
                                   && !ctrl_reg[1].rd_dma_ie |=> !irq_reg[1])
      else $error("channel 1 interrupt without master enable");
   a_trig_clear: assert property (chan_in[1].frame_done && !g_chan[1].ctrl_wr |=> !ctrl_reg[1].trig_en)
      else $error("trigger enable not cleared after frame");
   a_grant_onehot: assert property ($onehot0(grant_reg))
      else $error("more than one DMA grant");
   a_rst_inv: assert property (g_chan[1].ctrl_wr |=> chan_out[1].rx_fifo_rst_n == !$past(reg_wdata[1]))
      else $error("active-low reset output not inverted");

endmodule // slc_top
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the serial link control bank.
`timescale 1ns/100ps
`default_nettype none
module testbench import slc_pkg::*;;
   localparam logic [7:0] REV = 8'h3C;  // Arbitrary value.
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   logic [11:0]       reg_addr = 12'h000;
   logic [31:0]       reg_wdata = 32'h0000_0000;
   logic [31:0]       reg_rdata, txd, rxd;
   logic              pll_lock = 1'b1;
   logic              link_lock = 1'b0;
   logic              busy = 1'b0;
   logic [1:0]        ev = 2'h0;
   logic [1:0]        mode = 2'h1;
   logic [1:0]        grant;
   logic              txv, txr, rxv, rxr;
   slc_chan_in_t      chan_in [NUM_CH];
   slc_chan_out_t     chan_out [NUM_CH];
   logic [31:0]       words [$];
   int                failures = 0;
   int                checked = 0;
   int                cyc = 0;

   slc_top #(.CORE_REV(REV)) dut_u (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pll_lock_raw(pll_lock),
      .link_lock_raw(link_lock), .pll_busy(busy), .pll_done_evt(ev[0]), .pll_err_evt(ev[1]),
      .pll_tx_data(txd), .pll_tx_valid(txv), .pll_tx_ready(txr), .pll_rx_data(rxd), .pll_rx_valid(rxv),
      .pll_rx_ready(rxr), .chan_in(chan_in), .chan_out(chan_out), .dma_grant(grant));
   slc_pll_model pll_u (.clk(clk), .mode(mode), .tx_data(txd), .tx_valid(txv), .tx_ready(txr),
      .rx_data(rxd), .rx_valid(rxv), .rx_ready(rxr));

   always #50 clk = ~clk;
   always @(posedge clk)
      if (chan_out[0].rx_word_valid === 1'b1)
         words.push_back(chan_out[0].rx_word);
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic complete_run;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cy(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Reads a register and compares the bits under the mask.
   task automatic rc(input logic [11:0] a, input logic [31:0] m, e, input string n);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(n, e, reg_rdata & m);
   endtask

   task automatic t_reset;
      cy(3);
      #1;
      chk("tx_rst_n", 32'h1, {31'h0, chan_out[0].tx_fifo_rst_n});
      rc(OFS_CHAN0_CTRL, '1, CHAN_CTRL_RST, "ctrl0");
      rc(OFS_BASE_STATUS, '1, {4'h0, REV, 20'h1_1140}, "status");
      rc(12'h010, '1, 32'h0, "unmapped");
      @(posedge clk);
      busy <= 1'b1;
      link_lock <= 1'b1;
      cy(3);
      rc(OFS_BASE_STATUS, 32'h0001_00C0, 32'h0000_00C0, "busy lock");
      busy <= 1'b0;
   endtask
   task automatic t_ctrl;
      wr(OFS_CHAN1_CTRL, 32'hF9FF_FFFF);
      rc(OFS_CHAN1_CTRL, '1, 32'h093F_FFFF, "ctrl1");
      chk("rx_rst_n", 32'h0, {31'h0, chan_out[1].rx_fifo_rst_n});
      chk("irq1", 32'h1, {31'h0, chan_out[1].irq});
      chk("pattern", 32'h1, {31'h0, chan_out[1].tx_pattern_send});
      rc(OFS_BASE_STATUS, 32'h3, 32'h2, "irq bits");
      wr(OFS_CHAN1_CTRL, 32'h0000_0080);
      cy(2);
      #1;
      chk("irq1 off", 32'h0, {31'h0, chan_out[1].irq});
      chk("pattern off", 32'h0, {31'h0, chan_out[1].tx_pattern_send});
   endtask
   task automatic t_irq;
      logic [15:0] c [7] = '{16'h0140, 16'h0140, 16'h0100, 16'h0240, 16'h0240, 16'h1000, 16'h2000};
      logic [7:0]  t [7] = '{8'h04, 8'h05, 8'h00, 8'h05, 8'h05, 8'h05, 8'h05};
      logic [7:0]  r [7] = '{8'h00, 8'h00, 8'h00, 8'h0A, 8'h09, 8'h00, 8'h00};
      logic [6:0]  e = 7'h69;
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         chan_in[0].tx_count <= {8'h00, t[i]};
         chan_in[0].rx_count <= {8'h00, r[i]};
         chan_in[0].wr_dma_done <= (i == 5);
         chan_in[0].rd_dma_done <= (i == 6);
         wr(OFS_CHAN0_CTRL, {16'h0000, c[i]});
         cy(2);
         #1;
         chk("irq0", {31'h0, e[i]}, {31'h0, chan_out[0].irq});
      end
      wr(OFS_CHAN0_CTRL, 32'h0);
   endtask
   task automatic t_latch;
      logic [31:0] m;
      for (int i = 0; i < 2; i++)
      begin
         m = 32'h0002_0000 << i;
         @(posedge clk);
         ev[i] <= 1'b1;
         @(posedge clk);
         ev[i] <= 1'b0;
         rc(OFS_BASE_STATUS, m, m, "latched");
         wr(OFS_BASE_STATUS, ~m);
         rc(OFS_BASE_STATUS, m, m, "kept");
         wr(OFS_BASE_STATUS, m);
         rc(OFS_BASE_STATUS, m, 32'h0, "cleared");
      end
   endtask
   task automatic t_fifo;
      mode <= 2'h0;
      for (int k = 0; k < 34; k++)
         wr(OFS_PLL_FIFO, 32'hA000_0000 + k);
      rc(OFS_BASE_STATUS, 32'h0000_0700, 32'h0000_0600, "wr full");
      mode <= 2'h2;
      cy(100);
      chk("popped", 32'h0000_0021, pll_u.got.size());
      foreach (pll_u.got[k])
         chk("word out", 32'hA000_0000 + k, pll_u.got[k]);
      rc(OFS_BASE_STATUS, 32'h0000_0700, 32'h0000_0100, "wr empty");
      for (int k = 0; k < 3; k++)
         pll_u.feed.push_back(32'hB000_0000 + k);
      cy(8);
      rc(OFS_BASE_STATUS, 32'h0000_7000, 32'h0000_4000, "rd held");
      chk("rx ready", 32'h1, {31'h0, rxr});
      for (int k = 0; k < 4; k++)
      begin
         cy(3);
         rc(OFS_PLL_FIFO, '1, (k < 3) ? 32'hB000_0000 + k : 32'h0, "word in");
      end
      rc(OFS_BASE_STATUS, 32'h0000_7000, 32'h0000_1000, "rd empty");
   endtask
   task automatic t_pack;
      logic [7:0]  b [7] = '{8'h11, 8'hFF, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
      logic [31:0] x [3] = '{32'h4433_2211, 32'h0000_6655, 32'h1234_5678};
      wr(OFS_CHAN0_CTRL, 32'h0000_0800);
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         chan_in[0].rx_byte <= b[i];
         chan_in[0].rx_byte_valid <= 1'b1;
         chan_in[0].rx_byte_is_data <= (i != 1);
      end
      @(posedge clk);
      chan_in[0].rx_byte_valid <= 1'b0;
      wr(OFS_CHAN0_CTRL, 32'h0);
      cy(4);
      wr(OFS_CHAN0_CTRL, 32'h0000_0004);
      @(posedge clk);
      chan_in[0].tx_word <= 32'h1234_5678;
      chan_in[0].tx_word_valid <= 1'b1;
      #1;
      chk("pop", 32'h1, {31'h0, chan_out[0].tx_pop});
      @(posedge clk);
      chan_in[0].tx_word_valid <= 1'b0;
      wr(OFS_CHAN0_CTRL, 32'h0);
      chk("count", 32'h3, words.size());
      foreach (x[k])
         chk("word", x[k], words[k]);
   endtask
   task automatic t_misc;
      wr(OFS_CHAN1_CTRL, 32'h0000_4008);
      @(posedge clk);
      chan_in[1].frame_done <= 1'b1;
      chan_in[1].trig_req <= 1'b1;
      chan_in[1].tx_has_data <= 1'b1;
      chan_in[1].rx_wr_try <= 1'b1;
      chan_in[1].rx_full <= 1'b1;
      chan_in[1].wr_dma_req <= 1'b1;
      @(posedge clk);
      chan_in[1].frame_done <= 1'b0;
      chan_in[1].rx_wr_try <= 1'b0;
      chan_in[1].ovf_clr <= 1'b1;
      #1;
      chk("ovf", 32'h1, {31'h0, chan_out[1].ovf_latched});
      chk("grant", 32'h2, {30'h0, grant});
      chk("tx_go", 32'h1, {31'h0, chan_out[1].tx_go});
      rc(OFS_CHAN1_CTRL, '1, 32'h0000_0008, "trig clr");
      chan_in[1].ovf_clr <= 1'b0;
      chk("ovf clr", 32'h0, {31'h0, chan_out[1].ovf_latched});
      chk("tx_go off", 32'h0, {31'h0, chan_out[1].tx_go});
   endtask

   initial
   begin
      for (int i = 0; i < NUM_CH; i++)
      begin
         chan_in[i] = '0;
         chan_in[i].tx_count = 16'h0005;
         chan_in[i].tx_almost_empty_threshold = 16'h0004;
         chan_in[i].rx_almost_full_threshold = 16'h000A;
      end
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_ctrl();
      t_irq();
      t_latch();
      t_fifo();
      t_pack();
      t_misc();
      complete_run();
   end
endmodule  // testbench
`default_nettype wire
